// ==== scrh_pkg.sv ====
package scrh_pkg;

    // opcodes seen on the serial input
    localparam logic [7:0] OPC_READ_ONE = 8'h05;
    localparam logic [7:0] OPC_READ_TWO = 8'h35;
    localparam logic [7:0] OPC_READ_THREE = 8'h33;
    localparam logic [7:0] OPC_LATCH_SET = 8'h06;
    localparam logic [7:0] OPC_LATCH_CLEAR = 8'h04;
    localparam logic [7:0] OPC_VOLATILE_ARM = 8'h50;
    localparam logic [7:0] OPC_STATUS_WRITE = 8'h01;

    // field positions inside the seven writable bits of byte two
    localparam int CMP_POS = 6;
    localparam int LOCK_HI = 5;
    localparam int LOCK_LO = 2;
    localparam int QE_POS = 1;
    localparam int PROTECT_MODE_BIT_HIGH_POS = 0;

    // self-timed non-volatile write
    localparam int CLK_PERIOD_NS = 8;
    localparam int WRITE_TIME_NS = 10000;
    localparam int WRITE_CYCLES = WRITE_TIME_NS / CLK_PERIOD_NS;
    localparam int WCNT_W = 11;
    localparam logic [WCNT_W-1:0] WRITE_COUNT = WCNT_W'(WRITE_CYCLES);
    localparam logic [WCNT_W-1:0] WCNT_RST = 11'h000;

    // writable status bits: byte one 7..2, byte two 6..0, byte three 6..0
    typedef struct packed {
        logic [5:0] b1;
        logic [6:0] b2;
        logic [6:0] b3;
    } scrh_image_type;

    // serial pins from the host
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic si;
    } scrh_pins_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_OPCODE = 3'h1,
        ST_WDATA = 3'h3,
        ST_READ = 3'h2,
        ST_IGNORE = 3'h6
    } scrh_state_type;

    typedef enum logic [1:0] {
        CMD_NONE = 2'h0,
        CMD_SET = 2'h1,
        CMD_CLEAR = 2'h2,
        CMD_ARM = 2'h3
    } scrh_cmd_type;

    typedef enum logic [1:0] {
        SEL_ONE = 2'h0,
        SEL_TWO = 2'h1,
        SEL_THREE = 2'h2
    } scrh_sel_type;

    // values after reset
    localparam scrh_image_type IMAGE_RST = 20'h00000;
    localparam scrh_pins_type PINS_RST = 3'h4;
    localparam logic [2:0] CNT3_RST = 3'h0;
    localparam logic [1:0] DCNT_RST = 2'h0;
    localparam logic [7:0] BYTE_RST = 8'h00;

endpackage

// ==== scrh_status_cmd.sv ====
`timescale 1ns/1ps
module scrh_status_cmd (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST_N,
    // serial link from the host
    input wire scrh_pkg::scrh_pins_type PINS,
    output logic SO,
    output logic SO_OE,
    // non-volatile store image and working copy
    input wire scrh_pkg::scrh_image_type NV_IMAGE,
    output scrh_pkg::scrh_image_type NV_STORE,
    output scrh_pkg::scrh_image_type STATUS,
    // shared with the program and erase engines
    input wire logic OP_BUSY,
    input wire logic OP_DONE,
    output logic WRITE_LATCH,
    output logic BUSY
);

    scrh_pkg::scrh_pins_type pins_s1_q;
    scrh_pkg::scrh_pins_type pins_s2_q;
    scrh_pkg::scrh_pins_type pins_s3_q;
    scrh_pkg::scrh_state_type state_q;
    scrh_pkg::scrh_cmd_type cmd_q;
    scrh_pkg::scrh_sel_type sel_q;
    scrh_pkg::scrh_image_type wk_q;
    scrh_pkg::scrh_image_type nv_q;
    scrh_pkg::scrh_image_type pend_q;
    scrh_pkg::scrh_image_type new_d;
    logic [2:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic [7:0] rx_byte;
    logic [1:0] dcnt_q;
    logic [7:0] data1_q;
    logic [7:0] data2_q;
    logic [7:0] data3_q;
    logic [2:0] out_cnt_q;
    logic [7:0] out_sh_q;
    logic [7:0] cur_byte;
    logic [scrh_pkg::WCNT_W-1:0] wcnt_q;
    logic so_q;
    logic oe_q;
    logic wel_q;
    logic wbusy_q;
    logic vol_mode_q;
    logic vol_arm_q;
    logic init_q;
    logic cs_low;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;
    logic byte_done;
    logic busy;
    logic commit;
    logic commit_vol;
    logic commit_nv;
    logic wdone;
    logic latch_set;
    logic latch_clear;

    // two-stage synchroniser plus one stage for edge finding
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            pins_s1_q <= scrh_pkg::PINS_RST;
            pins_s2_q <= scrh_pkg::PINS_RST;
            pins_s3_q <= scrh_pkg::PINS_RST;
        end
        else
        begin
            pins_s1_q <= PINS;
            pins_s2_q <= pins_s1_q;
            pins_s3_q <= pins_s2_q;
        end
    end

    // frame and clock edges
    assign cs_low = !pins_s2_q.cs_n;
    assign cs_rise = pins_s2_q.cs_n && !pins_s3_q.cs_n;
    assign sclk_rise = cs_low && pins_s2_q.sclk && !pins_s3_q.sclk;
    assign sclk_fall = cs_low && !pins_s2_q.sclk && pins_s3_q.sclk;
    assign byte_done = sclk_rise && (bit_cnt_q == 3'h7);
    assign rx_byte = {shift_q[6:0], pins_s2_q.si};
    assign busy = wbusy_q | OP_BUSY;

    // input shifter, one bit per rising clock
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            bit_cnt_q <= scrh_pkg::CNT3_RST;
            shift_q <= scrh_pkg::BYTE_RST;
        end
        else if (!cs_low)
        begin
            bit_cnt_q <= scrh_pkg::CNT3_RST;
        end
        else if (sclk_rise)
        begin
            shift_q <= rx_byte;
            bit_cnt_q <= bit_cnt_q + 3'h1;
        end
    end

    // command decoder state machine
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            state_q <= scrh_pkg::ST_IDLE;
            cmd_q <= scrh_pkg::CMD_NONE;
            sel_q <= scrh_pkg::SEL_ONE;
            vol_mode_q <= 1'b0;
        end
        else if (!cs_low)
        begin
            state_q <= scrh_pkg::ST_IDLE;
        end
        else
        begin
            case (state_q)
                scrh_pkg::ST_IDLE:
                begin
                    state_q <= scrh_pkg::ST_OPCODE;
                    cmd_q <= scrh_pkg::CMD_NONE;
                end
                scrh_pkg::ST_OPCODE:
                begin
                    if (byte_done)
                    begin
                        state_q <= scrh_pkg::ST_IGNORE;
                        if (rx_byte == scrh_pkg::OPC_READ_ONE)
                        begin
                            state_q <= scrh_pkg::ST_READ;
                            sel_q <= scrh_pkg::SEL_ONE;
                        end
                        else if (busy)
                        begin
                            cmd_q <= scrh_pkg::CMD_NONE;
                        end
                        else if (rx_byte == scrh_pkg::OPC_READ_TWO)
                        begin
                            state_q <= scrh_pkg::ST_READ;
                            sel_q <= scrh_pkg::SEL_TWO;
                        end
                        else if (rx_byte == scrh_pkg::OPC_READ_THREE)
                        begin
                            state_q <= scrh_pkg::ST_READ;
                            sel_q <= scrh_pkg::SEL_THREE;
                        end
                        else if (rx_byte == scrh_pkg::OPC_LATCH_SET)
                            cmd_q <= scrh_pkg::CMD_SET;
                        else if (rx_byte == scrh_pkg::OPC_LATCH_CLEAR)
                            cmd_q <= scrh_pkg::CMD_CLEAR;
                        else if (rx_byte == scrh_pkg::OPC_VOLATILE_ARM)
                            cmd_q <= scrh_pkg::CMD_ARM;
                        else if (rx_byte == scrh_pkg::OPC_STATUS_WRITE &&
                                 (vol_arm_q || wel_q))
                        begin
                            state_q <= scrh_pkg::ST_WDATA;
                            vol_mode_q <= vol_arm_q;
                        end
                    end
                end
                scrh_pkg::ST_IGNORE:
                begin
                    // extra clocks spoil a one-byte command
                    if (sclk_rise)
                        cmd_q <= scrh_pkg::CMD_NONE;
                end
                scrh_pkg::ST_WDATA:
                begin
                    state_q <= scrh_pkg::ST_WDATA;
                end
                scrh_pkg::ST_READ:
                begin
                    state_q <= scrh_pkg::ST_READ;
                end
                default:
                begin
                    state_q <= scrh_pkg::ST_IGNORE;
                end
            endcase
        end
    end

    // one-byte commands act when select rises
    assign latch_set = cs_rise && state_q == scrh_pkg::ST_IGNORE &&
                       cmd_q == scrh_pkg::CMD_SET;
    assign latch_clear = cs_rise && state_q == scrh_pkg::ST_IGNORE &&
                         cmd_q == scrh_pkg::CMD_CLEAR;

    // volatile arm lives for the next opcode only
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
            vol_arm_q <= 1'b0;
        else if (cs_rise && state_q == scrh_pkg::ST_IGNORE &&
                 cmd_q == scrh_pkg::CMD_ARM)
            vol_arm_q <= 1'b1;
        else if (byte_done && state_q == scrh_pkg::ST_OPCODE)
            vol_arm_q <= 1'b0;
    end

    // status-write data bytes in order one, two, three
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            dcnt_q <= scrh_pkg::DCNT_RST;
            data1_q <= scrh_pkg::BYTE_RST;
            data2_q <= scrh_pkg::BYTE_RST;
            data3_q <= scrh_pkg::BYTE_RST;
        end
        else if (state_q == scrh_pkg::ST_OPCODE)
            dcnt_q <= scrh_pkg::DCNT_RST;
        else if (byte_done && state_q == scrh_pkg::ST_WDATA &&
                 dcnt_q != 2'h3)
        begin
            dcnt_q <= dcnt_q + 2'h1;
            if (dcnt_q == 2'h0)
                data1_q <= rx_byte;
            else if (dcnt_q == 2'h1)
                data2_q <= rx_byte;
            else
                data3_q <= rx_byte;
        end
    end

    // merge received bytes with current status
    always_comb
    begin
        new_d = wk_q;
        new_d.b1 = data1_q[7:2];
        if (dcnt_q >= 2'h2)
        begin
            new_d.b2 = data2_q[6:0];
            if (vol_mode_q)
            begin
                new_d.b2[scrh_pkg::LOCK_HI:scrh_pkg::LOCK_LO] =
                    wk_q.b2[scrh_pkg::LOCK_HI:scrh_pkg::LOCK_LO];
                new_d.b2[scrh_pkg::PROTECT_MODE_BIT_HIGH_POS] = wk_q.b2[scrh_pkg::PROTECT_MODE_BIT_HIGH_POS];
            end
            else
                new_d.b2[scrh_pkg::LOCK_HI:scrh_pkg::LOCK_LO] =
                    wk_q.b2[scrh_pkg::LOCK_HI:scrh_pkg::LOCK_LO] |
                    data2_q[scrh_pkg::LOCK_HI:scrh_pkg::LOCK_LO];
        end
        else if (!wk_q.b2[scrh_pkg::PROTECT_MODE_BIT_HIGH_POS])
        begin
            new_d.b2[scrh_pkg::CMP_POS] = 1'b0;
            new_d.b2[scrh_pkg::QE_POS] = 1'b0;
        end
        if (dcnt_q == 2'h3)
            new_d.b3 = data3_q[6:0];
    end

    // commit only on a clean byte boundary
    assign commit = cs_rise && state_q == scrh_pkg::ST_WDATA &&
                    bit_cnt_q == 3'h0 && dcnt_q != 2'h0;
    assign commit_vol = commit && vol_mode_q;
    assign commit_nv = commit && !vol_mode_q;
    assign wdone = wbusy_q && wcnt_q == 11'h001;

    // self-timed non-volatile update
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            wbusy_q <= 1'b0;
            wcnt_q <= scrh_pkg::WCNT_RST;
            pend_q <= scrh_pkg::IMAGE_RST;
        end
        else if (commit_nv)
        begin
            wbusy_q <= 1'b1;
            wcnt_q <= scrh_pkg::WRITE_COUNT;
            pend_q <= new_d;
        end
        else if (wbusy_q)
        begin
            wcnt_q <= wcnt_q - 11'h001;
            if (wdone)
                wbusy_q <= 1'b0;
        end
    end

    // working copy and non-volatile image
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            init_q <= 1'b1;
            wk_q <= scrh_pkg::IMAGE_RST;
            nv_q <= scrh_pkg::IMAGE_RST;
        end
        else if (init_q)
        begin
            init_q <= 1'b0;
            wk_q <= NV_IMAGE;
            nv_q <= NV_IMAGE;
        end
        else if (commit_vol)
            wk_q <= new_d;
        else if (wdone)
        begin
            wk_q <= pend_q;
            nv_q <= {pend_q.b1, pend_q.b2, nv_q.b3};
        end
    end

    // write latch, set beats clear
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
            wel_q <= 1'b0;
        else if (latch_set)
            wel_q <= 1'b1;
        else if (latch_clear || wdone || OP_DONE)
            wel_q <= 1'b0;
    end

    // selected status byte, sampled fresh per byte
    always_comb
    begin
        case (sel_q)
            scrh_pkg::SEL_ONE: cur_byte = {wk_q.b1, wel_q, busy};
            scrh_pkg::SEL_TWO: cur_byte = {1'b0, wk_q.b2};
            scrh_pkg::SEL_THREE: cur_byte = {1'b0, wk_q.b3};
            default: cur_byte = {wk_q.b1, wel_q, busy};
        endcase
    end

    // serial output on falling clock
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            so_q <= 1'b0;
            oe_q <= 1'b0;
            out_cnt_q <= scrh_pkg::CNT3_RST;
            out_sh_q <= scrh_pkg::BYTE_RST;
        end
        else if (!cs_low)
        begin
            oe_q <= 1'b0;
            out_cnt_q <= scrh_pkg::CNT3_RST;
        end
        else if (sclk_fall && state_q == scrh_pkg::ST_READ)
        begin
            oe_q <= 1'b1;
            out_cnt_q <= out_cnt_q + 3'h1;
            if (out_cnt_q == 3'h0)
            begin
                so_q <= cur_byte[7];
                out_sh_q <= {cur_byte[6:0], 1'b0};
            end
            else
            begin
                so_q <= out_sh_q[7];
                out_sh_q <= {out_sh_q[6:0], 1'b0};
            end
        end
    end

    assign SO = so_q;
    assign SO_OE = oe_q;
    assign NV_STORE = nv_q;
    assign STATUS = wk_q;
    assign WRITE_LATCH = wel_q;
    assign BUSY = busy;

    // length of the running self-timed write, for the bound checks
    logic [scrh_pkg::WCNT_W-1:0] wlen_q;

    // counts busy cycles of the status write, cleared when idle
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
            wlen_q <= scrh_pkg::WCNT_RST;
        else if (wbusy_q)
            wlen_q <= wlen_q + 11'h001;
        else
            wlen_q <= scrh_pkg::WCNT_RST;
    end

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);

    sequence s_nv_start;
        commit_nv ##1 wbusy_q;
    endsequence

    a_latch_set: assert property (latch_set |=> wel_q)
        else $error("latch not set after set command");
    a_latch_clear: assert property (latch_clear |=> !wel_q)
        else $error("latch not cleared after clear command");
    a_lock_sticky: assert property (!$past(init_q) |->
        ((wk_q.b2[5:2] & $past(wk_q.b2[5:2])) == $past(wk_q.b2[5:2])))
        else $error("lock bit returned to zero");
    a_busy_hold: assert property (s_nv_start |-> BUSY [*8])
        else $error("busy dropped early in status write");
    a_busy_end: assert property (wlen_q <= scrh_pkg::WRITE_COUNT)
        else $error("status write never finished");
    a_busy_length: assert property ($fell(wbusy_q) |->
        wlen_q == scrh_pkg::WRITE_COUNT)
        else $error("status write busy time wrong");
    a_done_latch: assert property ($fell(wbusy_q) |-> !wel_q)
        else $error("latch still set after status write");
    a_vol_quiet: assert property (commit_vol |=> !wbusy_q && wk_q == $past(new_d)
        && wel_q == $past(wel_q))
        else $error("volatile write not applied cleanly");
    a_bad_boundary: assert property (cs_rise && state_q == scrh_pkg::ST_WDATA &&
        bit_cnt_q != 3'h0 |=> wk_q == $past(wk_q) && !wbusy_q)
        else $error("misaligned status write took effect");
    a_so_release: assert property (cs_rise |=> !SO_OE)
        else $error("output still driven after deselect");
    a_read_msb: assert property (sclk_fall && state_q == scrh_pkg::ST_READ &&
        out_cnt_q == 3'h0 |=> SO == $past(cur_byte[7]))
        else $error("status byte msb not first");
    a_no_latch_write: assert property (state_q == scrh_pkg::ST_OPCODE &&
        byte_done && rx_byte == scrh_pkg::OPC_STATUS_WRITE && !wel_q &&
        !vol_arm_q |=> state_q != scrh_pkg::ST_WDATA)
        else $error("status write accepted without latch");

endmodule

// ==== scrh_host_model.sv ====
`timescale 1ns/1ps
module scrh_host_model (
    // clock
    input wire logic clock,
    // serial pins toward the device
    output scrh_pkg::scrh_pins_type pins,
    input wire logic so
);
    // ten system clocks per serial half period, 160 ns link clock
    localparam int HALF = 10;

    // idle: select high, serial clock parked low
    initial pins = scrh_pkg::PINS_RST;

    // wait a number of falling system clock edges
    task automatic idle(input int n);
        repeat (n) @(negedge clock);
    endtask

    // one framed transfer: whole bytes out, stray bits, bytes read back
    task automatic frame(input logic [7:0] tx[$], input int stray,
        input int nrd, output logic [7:0] rx[$]);
        int total;
        int first_rd;
        logic [7:0] sh;
        total = tx.size() * 8 + stray + nrd * 8;
        first_rd = total - nrd * 8;
        rx = {};
        sh = 8'h00;
        @(negedge clock);
        pins.cs_n = 1'b0;
        for (int b = 0; b < total; b++)
        begin
            // msb first, byte order as queued
            if (b < tx.size() * 8)
                pins.si = tx[b / 8][7 - (b % 8)];
            else
                pins.si = ~pins.si; // data not meaningful, keep it moving
            idle(HALF);
            pins.sclk = 1'b1;
            if (b >= first_rd)
            begin
                sh = {sh[6:0], so};
                if ((b - first_rd) % 8 == 7)
                    rx.push_back(sh);
            end
            idle(HALF);
            pins.sclk = 1'b0;
        end
        // select rises after the last whole bit
        idle(HALF);
        pins.cs_n = 1'b1;
        pins.si = ~pins.si;
        idle(HALF);
    endtask
endmodule

// ==== scrh_status_cmd_tb.sv ====
`timescale 1ns/1ps
module scrh_status_cmd_tb;
    logic clock;
    logic rst_n;
    logic so;
    logic so_oe;
    logic write_latch;
    logic busy;
    logic op_busy;
    logic op_done;
    logic exp_latch;
    logic [31:0] r32;
    logic [23:0] dd;
    logic [7:0] rx[$];
    logic [7:0] tq[$];
    int fail_count;
    int checks;
    int busy_cnt;
    int ncase[8] = '{3, 1, 3, 1, 2, 2, 1, 3};
    scrh_pkg::scrh_pins_type pins;
    scrh_pkg::scrh_image_type nv_image;
    scrh_pkg::scrh_image_type nv_store;
    scrh_pkg::scrh_image_type status;
    scrh_pkg::scrh_image_type exp_img;
    scrh_pkg::scrh_image_type exp_nv;

    scrh_status_cmd u_scrh_status_cmd (
        .CLOCK(clock), .RST_N(rst_n), .PINS(pins), .SO(so), .SO_OE(so_oe),
        .NV_IMAGE(nv_image), .NV_STORE(nv_store), .STATUS(status),
        .OP_BUSY(op_busy), .OP_DONE(op_done), .WRITE_LATCH(write_latch),
        .BUSY(busy)
    );

    // a released output shows the inverse of its last bit
    scrh_host_model u_scrh_host_model (
        .clock(clock), .pins(pins), .so(so_oe ? so : ~so)
    );

    // 125 MHz system clock
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // cycles spent busy since the last clear
    always @(negedge clock)
        if (busy === 1'b1)
            busy_cnt++;

    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%0h want=%0h", $time, seen, want);
        end
    endtask

    // counts, verdict, end of run
    task automatic results();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // expected byte on the serial output for a status read
    function automatic logic [7:0] rd_byte(input int sel, input logic bsy);
        if (sel == 0)
            return {exp_img.b1, exp_latch, bsy};
        if (sel == 1)
            return {1'b0, exp_img.b2};
        return {1'b0, exp_img.b3};
    endfunction

    // expected working copy after a write with n whole data bytes
    function automatic scrh_pkg::scrh_image_type next_img(
        input scrh_pkg::scrh_image_type c, input logic vol, input int n,
        input logic [23:0] d);
        scrh_pkg::scrh_image_type r;
        r = c;
        r.b1 = d[23:18];
        if (n == 1 && c.b2[scrh_pkg::PROTECT_MODE_BIT_HIGH_POS] == 1'b0)
        begin
            r.b2[scrh_pkg::CMP_POS] = 1'b0;
            r.b2[scrh_pkg::QE_POS] = 1'b0;
        end
        if (n >= 2)
            r.b2 = d[14:8];
        if (n >= 2 && vol)
        begin
            r.b2[5:2] = c.b2[5:2];
            r.b2[scrh_pkg::PROTECT_MODE_BIT_HIGH_POS] = c.b2[scrh_pkg::PROTECT_MODE_BIT_HIGH_POS];
        end
        if (n >= 2 && !vol)
            r.b2[5:2] = d[13:10] | c.b2[5:2];
        if (n >= 3)
            r.b3 = d[6:0];
        return r;
    endfunction

    // status read of byte sel, nb bytes long
    task automatic rd(input int sel, input int nb, input logic bsy);
        tq = {sel == 0 ? scrh_pkg::OPC_READ_ONE :
            sel == 1 ? scrh_pkg::OPC_READ_TWO : scrh_pkg::OPC_READ_THREE};
        u_scrh_host_model.frame(tq, 0, nb, rx);
        for (int i = 0; i < nb; i++)
            check(rx[i], rd_byte(sel, bsy));
        check(so_oe, 1'b0);
    endtask

    // one-byte command frame
    task automatic cmd1(input logic [7:0] opc);
        tq = {opc};
        u_scrh_host_model.frame(tq, 0, 0, rx);
    endtask

    // enable then status write; poll reads byte one across the busy time
    task automatic wr(input logic vol, input int n, input logic [23:0] d,
        input int stray, input logic poll);
        scrh_pkg::scrh_image_type nxt;
        int k;
        // enable precedes the write
        cmd1(vol ? scrh_pkg::OPC_VOLATILE_ARM : scrh_pkg::OPC_LATCH_SET);
        if (!vol)
            exp_latch = 1'b1;
        check(write_latch, exp_latch);
        tq = {scrh_pkg::OPC_STATUS_WRITE};
        for (k = 0; k < n; k++)
            tq.push_back(d[23 - 8 * k -: 8]);
        busy_cnt = 0;
        u_scrh_host_model.frame(tq, stray, 0, rx);
        nxt = (stray != 0 || n == 0) ? exp_img : next_img(exp_img, vol, n, d);
        if (!vol && stray == 0 && n > 0)
        begin
            check(busy, 1'b1);
            if (poll)
            begin
                tq = {scrh_pkg::OPC_READ_ONE};
                u_scrh_host_model.frame(tq, 0, 10, rx);
                check(rx[0], {exp_img.b1, 2'b11});
                check(rx[9], {nxt.b1, 2'b00});
            end
            k = 0;
            while (busy !== 1'b0 && k < 3000)
            begin
                @(negedge clock);
                k++;
            end
            if (k == 3000)
            begin
                fail_count++;
                results();
            end
            check(busy_cnt, scrh_pkg::WRITE_CYCLES);
            exp_latch = 1'b0;
            exp_nv.b1 = nxt.b1;
            exp_nv.b2 = nxt.b2;
        end
        else
            check(busy_cnt, 0);
        exp_img = nxt;
        check(status, exp_img);
        check(write_latch, exp_latch);
        check({nv_store.b1, nv_store.b2}, {exp_nv.b1, exp_nv.b2});
        rd(1, 1, 1'b0);
        rd(2, 1, 1'b0);
    endtask

    // main sequence
    initial
    begin
        rst_n = 1'b0;
        op_busy = 1'b0;
        op_done = 1'b0;
        fail_count = 0;
        checks = 0;
        busy_cnt = 0;
        exp_latch = 1'b0;
        r32 = $urandom(56021);
        r32 = $urandom;
        nv_image = r32[19:0];
        repeat (8) @(negedge clock);
        rst_n = 1'b1;
        exp_img = nv_image;
        exp_nv = nv_image;
        repeat (6) @(negedge clock);
        check(status, nv_image);
        check(nv_store, nv_image);
        check(write_latch, 1'b0);
        // reads of all three bytes while idle, two bytes each
        for (int s = 0; s < 3; s++)
            rd(s, 2, 1'b0);
        cmd1(scrh_pkg::OPC_LATCH_SET);
        exp_latch = 1'b1;
        rd(0, 1, 1'b0);
        cmd1(scrh_pkg::OPC_LATCH_CLEAR);
        exp_latch = 1'b0;
        check(write_latch, 1'b0);
        // write without the latch is ignored
        busy_cnt = 0;
        r32 = $urandom;
        tq = {scrh_pkg::OPC_STATUS_WRITE, r32[23:16], r32[15:8], r32[7:0]};
        u_scrh_host_model.frame(tq, 0, 0, rx);
        check(status, exp_img);
        check(busy_cnt, 0);
        // another engine busy: byte one still answers, enable refused
        op_busy = 1'b1;
        rd(0, 1, 1'b1);
        cmd1(scrh_pkg::OPC_LATCH_SET);
        op_busy = 1'b0;
        check(write_latch, 1'b0);
        // another engine completes: latch dropped
        cmd1(scrh_pkg::OPC_LATCH_SET);
        check(write_latch, 1'b1);
        op_done = 1'b1;
        @(negedge clock);
        op_done = 1'b0;
        @(negedge clock);
        check(write_latch, 1'b0);
        exp_latch = 1'b0;
        // random writes, truncations under both protect settings
        for (int i = 0; i < 8; i++)
        begin
            r32 = $urandom;
            dd = r32[23:0];
            dd[8] = i[1];
            dd[15] = 1'b0; // reserved bits at default
            dd[7] = 1'b0;
            // last write gives back byte three as just read
            if (i == 7)
                dd[6:0] = rx[0][6:0];
            wr(i[0], ncase[i], dd, 0, i == 2);
        end
        // select off a byte boundary, then no data at all
        r32 = $urandom;
        wr(1'b0, 2, r32[23:0], 3, 1'b0);
        wr(1'b0, 0, r32[23:0], 0, 1'b0);
        cmd1(scrh_pkg::OPC_LATCH_CLEAR);
        check(write_latch, 1'b0);
        results();
    end
endmodule
